// >>> design/standalone_watchdog_timer.sv
/*
  Standalone watchdog timer: kick input, active-low enable,
  open-drain active-low alarm. All timing from the core clock.
  Assumes kick and enable arrive asynchronously from pins and
  that a pad outside resolves the open-drain alarm wire.
*/
// Notes on behaviour
// - Each valid kick clears the counter
// - Timeout reached drives alarm pin low
// - Timeout period chosen from six options
// - Hold option fixes alarm low time
// - Enable input high disables the watchdog
// - Enable input defaults low, watchdog enabled
// - Enable pulse resets, glitches are rejected
// - Alarm stays low 20us despite disable
// - No-hold alarm stays low 20us despite kicks
// - Alarm transitions restart the counter
// - Kick pulses filtered, glitches ignored
// - No-hold variant clears on rising only
// - Alarm repeats each period without kicks
// - Disable clears timing, restart from zero
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.svh"

module standalone_watchdog_timer #(
  parameter int unsigned TIMEOUT_OPT = 0,
  parameter int unsigned HOLD_OPT    = 1,
  parameter bit          BOTH_EDGES  = (HOLD_OPT != 0),
  // selected timeout, overridable to shorten simulation
  parameter int unsigned TWD_CYC     = watchdog_pkg::timeout_cyc(TIMEOUT_OPT),
  // selected hold time, overridable to shorten simulation
  parameter int unsigned HOLD_CYC    = watchdog_pkg::hold_cyc(HOLD_OPT)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic kick_input_i,
  input  wire logic watchdog_off_in_i,
  input  wire logic alarm_out_low_i,
  output logic      alarm_out_low_o,
  output logic      alarm_out_low_oe_o
);
  import watchdog_pkg::*;

  localparam bit   HAS_HOLD = (HOLD_OPT != 0);
  localparam cnt_t TWD_LAST = cnt_t'(TWD_CYC - 1);
  localparam cnt_t END_LAST = HAS_HOLD ? cnt_t'(HOLD_CYC - 1) : TWD_LAST;
  localparam cnt_t MIN_LAST = cnt_t'(`MIN_LOW_CYC - 1);
  localparam int   NS       = `FILT_STAGES;

  // ==========================================================
  // Input conditioning
  logic [1:0] raw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] filt_q;
  logic       kick_prev_q;

  assign raw = {watchdog_off_in_i, kick_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      localparam logic RV = (gi == 1) ? `OFF_RST_VAL : `KICK_RST_VAL;
      logic [NS-1:0] hist_q;
      // enabled until the input says otherwise
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_q[gi] <= RV;
          sync2_q[gi] <= RV;
        end else begin
          sync1_q[gi] <= raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
      // a level must stand NS samples to pass
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          hist_q     <= {NS{RV}};
          filt_q[gi] <= RV;
        end else begin
          hist_q <= {hist_q[NS-2:0], sync2_q[gi]};
          if (&{hist_q[NS-2:0], sync2_q[gi]}) begin
            filt_q[gi] <= 1'b1;
          end else if (~|{hist_q[NS-2:0], sync2_q[gi]}) begin
            filt_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      kick_prev_q <= `KICK_RST_VAL;
    end else begin
      kick_prev_q <= filt_q[0];
    end
  end

  logic off;
  logic kick_rise;
  logic kick_fall;
  logic kick_hit;

  // high level of the enable input switches off
  assign off       = filt_q[1];
  assign kick_rise = filt_q[0] & ~kick_prev_q;
  assign kick_fall = ~filt_q[0] & kick_prev_q;
  assign kick_hit  = kick_rise | (BOTH_EDGES & kick_fall);

  // ==========================================================
  // Sequencer
  wd_state_t state_q;
  cnt_t      cnt_q;
  logic      alarm_q;
  logic      pend_q;
  logic      len_ok;
  logic      stop_req;

  assign len_ok   = (cnt_q >= MIN_LAST);
  // disable during alarm waits for the least low time
  // no-hold kick only ends alarm after the least low time
  assign stop_req = off | pend_q | (kick_rise & ~HAS_HOLD);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_COUNT;
      cnt_q   <= '0;
      alarm_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_OFF: begin
          // timing cleared while off, restart from zero
          cnt_q   <= '0;
          alarm_q <= 1'b0;
          if (!off) begin
            state_q <= S_COUNT;
          end
        end
        S_COUNT: begin
          if (off) begin
            state_q <= S_OFF;
            cnt_q   <= '0;
          end else if (kick_hit) begin
            cnt_q <= '0;
          end else if (cnt_q == TWD_LAST) begin
            state_q <= S_ALARM;
            alarm_q <= 1'b1;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        S_ALARM: begin
          if ((stop_req && len_ok) || cnt_q == END_LAST) begin
            // release, then count a fresh period, or go to S_OFF if disabled
            state_q <= off ? S_OFF : S_COUNT;
            alarm_q <= 1'b0;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= S_OFF;
          cnt_q   <= '0;
          alarm_q <= 1'b0;
        end
      endcase
    end
  end

  // Remembers a release request seen before the least low time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (state_q != S_ALARM || !alarm_q) begin
      pend_q <= 1'b0;
    end else if ((stop_req && len_ok) || cnt_q == END_LAST) begin
      pend_q <= 1'b0;
    end else if (off || (kick_rise && !HAS_HOLD)) begin
      pend_q <= 1'b1;
    end
  end

  // ==========================================================
  // Open-drain alarm pin: only ever pulls low
  assign alarm_out_low_o    = 1'b0;
  assign alarm_out_low_oe_o = alarm_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  kick_clears_a: assert property (
    state_q == S_COUNT && !off && kick_hit |=> cnt_q == '0)
    else $error("kick did not clear the counter");

  timeout_fires_a: assert property (
    state_q == S_COUNT && !off && !kick_hit && cnt_q == TWD_LAST
    |=> alarm_out_low_oe_o && cnt_q == '0)
    else $error("timeout did not assert the alarm");

  hold_length_a: assert property (
    HAS_HOLD && alarm_q && cnt_q == END_LAST |=> !alarm_q)
    else $error("alarm held past its fixed time");

  min_low_off_a: assert property (
    alarm_q && cnt_q < MIN_LAST && off |=> alarm_q)
    else $error("disable cut the alarm short");

  min_low_kick_a: assert property (
    alarm_q && cnt_q < MIN_LAST |=> alarm_out_low_oe_o)
    else $error("alarm released before the least low time");

  edge_sense_a: assert property (
    !BOTH_EDGES && state_q == S_COUNT && !off && kick_fall
    && cnt_q < TWD_LAST |=> cnt_q == $past(cnt_q) + 32'h0000_0001)
    else $error("falling kick edge cleared the counter");

  off_clears_a: assert property (
    off && !alarm_q |-> ##[1:2] state_q == S_OFF && cnt_q == '0)
    else $error("disable did not clear timing");

  filter_stable_a: assert property (
    $changed(filt_q[0]) |-> $past(sync2_q[0], 2) == filt_q[0])
    else $error("kick filter passed an unstable level");

  restart_a: assert property (
    $fell(alarm_q) && !$past(off) |-> state_q == S_COUNT && cnt_q == '0)
    else $error("count did not restart after alarm");

  timeout_seen_c: cover property ($rose(alarm_q));
  kick_seen_c:    cover property (state_q == S_COUNT && kick_hit);
  off_alarm_c:    cover property (alarm_q && off ##1 alarm_q);
  pin_low_c:      cover property (alarm_q && !alarm_out_low_i);

endmodule // standalone_watchdog_timer

`default_nettype wire

// >>> design/watchdog_map.svh
/*
  Timing and reset constants of the standalone watchdog.
  Assumes a 10 MHz core clock; all counts derive from it.
*/
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ==========================================================
// Clock rate
`define CLK_MHZ          10
`define US_TO_CYC(t)     ((t) * `CLK_MHZ)

// ==========================================================
// Timeout periods, options A..F, in microseconds
`define TWD_A_US         3400
`define TWD_B_US         6800
`define TWD_C_US         108800
`define TWD_D_US         1700000
`define TWD_E_US         7000000
`define TWD_F_US         27900000

// ==========================================================
// Fixed alarm hold times, options A and B, in microseconds
`define HOLD_A_US        27200
`define HOLD_B_US        217600

// ==========================================================
// Least alarm low time
`define MIN_LOW_US       20
`define MIN_LOW_CYC      `US_TO_CYC(`MIN_LOW_US)

// ==========================================================
// Input glitch rejection, rounded up to whole cycles
`define GLITCH_NS        100
`define GLITCH_CYC       (((`GLITCH_NS * `CLK_MHZ) + 999) / 1000)
`define FILT_STAGES      (`GLITCH_CYC + 1)

// ==========================================================
// Reset values
`define OFF_RST_VAL      1'b0
`define KICK_RST_VAL     1'b0

`endif

// >>> design/watchdog_pkg.sv
/*
  Types and option decoders of the standalone watchdog.
  Assumes watchdog_map.svh is on the include path.
*/
`default_nettype none
`include "watchdog_map.svh"

package watchdog_pkg;

  // ========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    S_OFF   = 2'b00,
    S_COUNT = 2'b01,
    S_ALARM = 2'b10
  } wd_state_t;

  typedef logic [31:0] cnt_t;

  // ========================================================
  // Option decoders: timeout 0..5 is A..F, hold 0 none, 1 A, 2 B
  function automatic int unsigned timeout_cyc(input int unsigned opt);
    case (opt)
      0:       timeout_cyc = `US_TO_CYC(`TWD_A_US);
      1:       timeout_cyc = `US_TO_CYC(`TWD_B_US);
      2:       timeout_cyc = `US_TO_CYC(`TWD_C_US);
      3:       timeout_cyc = `US_TO_CYC(`TWD_D_US);
      4:       timeout_cyc = `US_TO_CYC(`TWD_E_US);
      default: timeout_cyc = `US_TO_CYC(`TWD_F_US);
    endcase
  endfunction

  function automatic int unsigned hold_cyc(input int unsigned opt);
    case (opt)
      1:       hold_cyc = `US_TO_CYC(`HOLD_A_US);
      2:       hold_cyc = `US_TO_CYC(`HOLD_B_US);
      default: hold_cyc = 0;
    endcase
  endfunction

endpackage

`default_nettype wire

// >>> tb/kick_host.sv
/*
  Supervised processor model: toggles the kick pin at a set gap.
  Assumes the bench sets gap and calls pulse between toggles.
*/
`timescale 1ns/1ps
`default_nettype none

module kick_host (
  input  wire logic clk_i,
  output logic      kick_o
);
  // ==========================================================
  // Toggle engine; gap 0 stops at once, so the pin holds its level
  int unsigned gap  = 0;
  int unsigned step = 0;
  initial kick_o = 1'b0;
  always @(negedge clk_i) begin
    if (gap == 0) begin
      step = 0;
    end else if (step + 1 >= gap) begin
      step = 0;
      kick_o = ~kick_o;
    end else begin
      step++;
    end
  end

  // Parked low, so reset never sees a stale high level as an edge
  task automatic park();
    gap = 0;
    kick_o = 1'b0;
  endtask

  task automatic pulse(input int unsigned n);
    kick_o = ~kick_o;
    repeat (n) @(negedge clk_i);
    kick_o = ~kick_o;
  endtask
endmodule // kick_host

`default_nettype wire

// >>> tb/testbench.sv
/*
  Self-checking bench of the watchdog with shortened counts.
  Runs a hold variant and a no-hold variant side by side.
  Assumes pulled-up alarm wires.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import watchdog_pkg::*;
  localparam int unsigned TWD  = 400;
  localparam int unsigned HOLD = 300;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        off_i = 1'b0;
  logic        kick;
  logic        drv;
  logic        oe;
  logic        wire_lvl;
  logic        drv2;
  logic        oe2;
  logic        wire2;
  int unsigned fail_count = 0;
  int unsigned total_checks = 0;
  int unsigned n;

  // Open-drain wire with external pull-up
  assign wire_lvl = oe ? drv : 1'b1;
  assign wire2    = oe2 ? drv2 : 1'b1;

  standalone_watchdog_timer #(.TIMEOUT_OPT(0), .HOLD_OPT(1), .TWD_CYC(TWD),
    .HOLD_CYC(HOLD)) dut_u (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .kick_input_i      (kick),
    .watchdog_off_in_i (off_i),
    .alarm_out_low_i   (wire_lvl),
    .alarm_out_low_o   (drv),
    .alarm_out_low_oe_o(oe)
  );
  standalone_watchdog_timer #(.TIMEOUT_OPT(0), .HOLD_OPT(0), .TWD_CYC(TWD)) nohold_u (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .kick_input_i      (kick),
    .watchdog_off_in_i (off_i),
    .alarm_out_low_i   (wire2),
    .alarm_out_low_o   (drv2),
    .alarm_out_low_oe_o(oe2)
  );
  kick_host host_u (.clk_i(clk_i), .kick_o(kick));

  initial forever #50 clk_i = ~clk_i;

  // ==========================================================
  // Helpers
  task automatic conclude();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_level(input logic got, input logic want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%0h want=%0h", $time, got, want);
    end
  endtask

  task automatic check_range(input int unsigned got, input int unsigned lo,
                             input int unsigned hi);
    total_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("BAD t=%0t got=%0h want=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  // Cycles until the alarm enable reaches v, capped at lim
  task automatic wait_oe(input logic v, input int unsigned lim);
    n = 0;
    while (oe !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  // Same for the no-hold instance
  task automatic wait_nh(input logic v, input int unsigned lim);
    n = 0;
    while (oe2 !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic restart();
    host_u.park();
    off_i = 1'b0;
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_repeat();
    restart();
    wait_oe(1'b1, 900); check_range(n, TWD - 2, TWD + 3);
    check_level(wire_lvl, 1'b0);
    wait_oe(1'b0, 900); check_range(n, HOLD - 1, HOLD + 1);
    check_level(wire_lvl, 1'b1);
    wait_oe(1'b1, 900); check_range(n, TWD - 1, TWD + 2);
  endtask

  task automatic t_kicks();
    restart();
    host_u.gap = 150;
    wait_oe(1'b1, 2000); check_range(n, 2000, 2000);
    // Rising-only clearing would let 600-cycle gaps time out
    host_u.gap = 300;
    wait_oe(1'b1, 2000); check_range(n, 2000, 2000);
  endtask

  task automatic t_glitch();
    restart();
    repeat (200) @(negedge clk_i);
    host_u.pulse(1);
    wait_oe(1'b1, 900); check_range(n, TWD - 204, TWD - 196);
  endtask

  task automatic t_off_pulse();
    restart();
    repeat (300) @(negedge clk_i);
    off_i = 1'b1;
    @(negedge clk_i);
    off_i = 1'b0;
    wait_oe(1'b1, 900); check_range(n, TWD - 304, TWD - 296);
    restart();
    repeat (300) @(negedge clk_i);
    off_i = 1'b1;
    repeat (15) @(negedge clk_i);
    off_i = 1'b0;
    wait_oe(1'b1, 900); check_range(n, TWD, TWD + 8);
  endtask

  task automatic t_off();
    restart();
    repeat (100) @(negedge clk_i);
    off_i = 1'b1;
    wait_oe(1'b1, 1000); check_range(n, 1000, 1000);
    off_i = 1'b0;
    wait_oe(1'b1, 900); check_range(n, TWD, TWD + 8);
  endtask

  task automatic t_off_in_alarm();
    restart();
    wait_oe(1'b1, 900);
    repeat (5) @(negedge clk_i);
    off_i = 1'b1;
    wait_oe(1'b0, 400); check_range(n, 190, 197);
    wait_oe(1'b1, 500); check_range(n, 500, 500);
  endtask

  // No-hold variant: kicks cannot cut the least low time, falls ignored
  task automatic t_nohold();
    restart();
    wait_nh(1'b1, 900);
    check_range(n, TWD - 2, TWD + 3);
    repeat (10) @(negedge clk_i);
    host_u.pulse(20);
    wait_nh(1'b0, 400);
    check_range(n, 168, 172);
    host_u.pulse(300);
    wait_nh(1'b1, 900);
    check_range(n, 103, 107);
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    t_repeat();
    t_kicks();
    t_glitch();
    t_off_pulse();
    t_off();
    t_off_in_alarm();
    t_nohold();
    conclude();
  end

  initial begin
    #(60000 * 100);
    fail_count++;
    conclude();
  end
endmodule // testbench

`default_nettype wire
